// *** logic/tsd_coarse.sv ***
// tsd_coarse: integrator/comb decimator with bypass
// assumes: in_valid is a one-cycle strobe per sample; out may stall
`timescale 1ns/1ps
`default_nettype none

module tsd_coarse
	import tsd_pkg::*;
#(
	parameter int IN_W   = SAMPLE_W,
	parameter int OUT_W  = RESULT_W,
	parameter int STAGES = COARSE_STAGES,
	parameter int RATE_W = CC_RATE_W
)(
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic              in_valid,
	input  wire logic [IN_W-1:0]   in_data,
	input  wire logic [RATE_W-1:0] rate_m1,
	input  wire logic              bypass,
	tsd_stream_if.src              out,
	output logic                   overrun
);
	localparam int CW = IN_W + STAGES * RATE_W;

	logic signed [CW-1:0] integ_ff [STAGES];
	logic signed [CW-1:0] dly_ff   [STAGES];
	logic [RATE_W-1:0]    cnt_ff;
	logic                 valid_ff;
	logic [OUT_W-1:0]     data_ff;

	wire signed [CW-1:0] integ_in [STAGES+1];
	wire signed [CW-1:0] comb_v   [STAGES+1];
	wire                 dec_stb     = in_valid & ~bypass & (cnt_ff == rate_m1);
	wire                 produce     = bypass ? in_valid : dec_stb;
	wire                 slot_free   = ~valid_ff | out.ready;
	// fractional input lands in the top bits of the wide word
	wire [OUT_W-1:0]     bypass_word = {in_data, {(OUT_W-IN_W){1'b0}}};
	// full-scale slice; low rates lose gain, no growth shifter here
	wire [OUT_W-1:0]     nxt_data    = bypass ? bypass_word : comb_v[STAGES][CW-1 -: OUT_W];

	assign integ_in[0] = CW'(signed'(in_data));
	assign comb_v[0]   = integ_ff[STAGES-1];
	assign out.valid   = valid_ff;
	assign out.data    = data_ff;

	for (genvar g = 0; g < STAGES; g++) begin : g_stage
		assign integ_in[g+1] = integ_ff[g];
		assign comb_v[g+1]   = comb_v[g] - dly_ff[g];
		always_ff @(posedge clk_sys) begin
			if (sys_rst) begin
				integ_ff[g] <= '0;
				dly_ff[g]   <= '0;
			end else begin
				if (in_valid) integ_ff[g] <= integ_ff[g] + integ_in[g];
				if (dec_stb) dly_ff[g] <= comb_v[g];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) cnt_ff <= '0;
		else if (in_valid) cnt_ff <= (cnt_ff == rate_m1) ? '0 : cnt_ff + 1'b1;
	end

	// a stalled slot keeps its word; the newer result is dropped and flagged
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			valid_ff <= 1'b0;
			data_ff  <= '0;
			overrun  <= 1'b0;
		end else begin
			overrun <= produce & ~slot_free;
			if (produce && slot_free) begin
				valid_ff <= 1'b1;
				data_ff  <= nxt_data;
			end else if (out.ready) begin
				valid_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_decim_out;
		$rose(out.valid) && !bypass |-> $past(in_valid && cnt_ff == rate_m1);
	endproperty
	a_decim_out: assert property (p_decim_out) else $error("coarse output off its decimation slot");

	property p_bypass_word;
		in_valid && bypass && slot_free |=> out.valid && out.data == $past(bypass_word);
	endproperty
	a_bypass_word: assert property (p_bypass_word) else $error("bypass sample not forwarded");

endmodule : tsd_coarse

`default_nettype wire

// *** logic/tsd_fifo.sv ***
// tsd_fifo: word fifo between coarse and tap stages
// assumes: DEPTH is a power of two; clk_sys domain on both sides
`timescale 1ns/1ps
`default_nettype none

module tsd_fifo
	import tsd_pkg::*;
#(
	parameter int W     = RESULT_W,
	parameter int DEPTH = FIFO_DEPTH
)(
	input  wire logic   clk_sys,
	input  wire logic   sys_rst,
	tsd_stream_if.snk   wr,
	tsd_stream_if.src   rd
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_ff [DEPTH];
	logic [AW:0]  wp_ff;
	logic [AW:0]  rp_ff;

	wire full  = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
	wire empty = (wp_ff == rp_ff);
	wire push  = wr.valid & wr.ready;
	wire pop   = rd.valid & rd.ready;

	assign wr.ready = ~full;
	assign rd.valid = ~empty;
	assign rd.data  = mem_ff[rp_ff[AW-1:0]];

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wp_ff <= '0;
			rp_ff <= '0;
		end else begin
			if (push) wp_ff <= wp_ff + 1'b1;
			if (pop) rp_ff <= rp_ff + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) mem_ff[wp_ff[AW-1:0]] <= wr.data;
	end

endmodule : tsd_fifo

`default_nettype wire

// *** logic/tsd_pkg.sv ***
// tsd_pkg: shared constants for the two-stage decimating filter
// assumes: single system clock; every module imports this package whole
`default_nettype none

package tsd_pkg;

	localparam int SAMPLE_W        = 16;
	localparam int RESULT_W        = 24;
	localparam int COEF_W          = 20;
	localparam int CTRL_W          = 16;
	localparam int COARSE_STAGES   = 5;
	localparam int FIFO_DEPTH      = 8;
	localparam int COEF_FRAC       = 19;
	localparam int MAX_TAPS        = 512;
	localparam int COEF_DEPTH      = MAX_TAPS / 2;
	localparam int TAP_AW          = $clog2(MAX_TAPS);
	localparam int COEF_AW         = $clog2(COEF_DEPTH);
	localparam int PROD_W          = RESULT_W + COEF_W;
	localparam int ACC_W           = PROD_W + TAP_AW;
	localparam int SYS_CLK_HZ      = 40_000_000;
	localparam int STAGE_CLK_MAX_HZ = 33_000_000;

	////////////////////////////////////////////////////////////////////////
	// register select codes
	localparam logic [1:0] SEL_COARSE  = 2'h0;
	localparam logic [1:0] SEL_TAP     = 2'h1;
	localparam logic [1:0] SEL_COEF_LO = 2'h2;
	localparam logic [1:0] SEL_COEF_HI = 2'h3;

	// coarse config fields
	localparam int CC_RATE_LSB = 0;
	localparam int CC_RATE_W   = 10;
	localparam int CC_BYP_BIT  = 10;
	// tap stage config fields
	localparam int TC_BYP_BIT  = 0;
	localparam int TC_DIS_BIT  = 1;
	localparam int TC_DEC_LSB  = 2;
	localparam int TC_DEC_W    = 4;
	localparam int TC_NTAP_LSB = 6;
	// coefficient high word fields
	localparam int CH_HI_LSB   = 0;
	localparam int CH_HI_W     = COEF_W - CTRL_W;
	localparam int CH_ADDR_LSB = 4;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [CTRL_W-1:0] COARSE_CFG_RST = 16'h0000;
	localparam logic [CTRL_W-1:0] TAP_CFG_RST    = 16'h0002;
	// sample_clk, tap_stage_clk, go_n, wr_n, cs_n, out_en_n
	localparam logic [5:0]        PIN_CTL_RST    = 6'h0f;

	typedef enum logic {TSD_IDLE, TSD_MAC} tsd_fir_state_t;

endpackage : tsd_pkg

`default_nettype wire

// *** logic/tsd_stream_if.sv ***
// tsd_stream_if: valid/ready word stream between filter sections
// assumes: both ends clocked by clk_sys
`timescale 1ns/1ps
`default_nettype none

interface tsd_stream_if #(
	parameter int W = 24
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : tsd_stream_if

`default_nettype wire

// *** logic/tsd_top.sv ***
// tsd_top: two-stage decimating filter, coarse section then tap section
// assumes: pins asynchronous to clk_sys (40 MHz); stage clocks slower than clk_sys / 2
// Behaviour
// - coarse section steps on sample_clk rising edges
// - tap section steps on tap_stage_clk rising edges
// - sixteen-bit sample captured on sample_clk rise
// - samples are two's-complement fractions
// - coarse section feeds the tap section
// - coarse decimation programmable up to 1024
// - transversal filter, up to 512 symmetric taps
// - tap section decimates up to 16 more
// - tap coefficients are twenty bits wide
// - result word is twenty-four bits wide
// - either section may be bypassed
// - result driven through three-state enables
// - sixteen-bit processor-style control port
// - chip select, write low; load on rise
// - one-cycle result_valid per finished tap result
// - reset clears rate, bypass; sets disable
`timescale 1ns/1ps
`default_nettype none

module tsd_top
	import tsd_pkg::*;
#(
	parameter int FIFO_D = FIFO_DEPTH
)(
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	input  wire logic                sample_clk,
	input  wire logic                tap_stage_clk,
	input  wire logic [SAMPLE_W-1:0] sample_in,
	input  wire logic                go_n,
	input  wire logic                wr_n,
	input  wire logic                cs_n,
	input  wire logic [1:0]          reg_select,
	input  wire logic [CTRL_W-1:0]   control_word,
	input  wire logic                out_en_n,
	output logic [RESULT_W-1:0]      result_out,
	output logic                     result_oe,
	output logic                     result_valid,
	output logic                     running,
	output logic                     overrun
);
	localparam int SYNC_W = SAMPLE_W + CTRL_W + 8;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [SYNC_W-1:0] sync1_ff;
	logic [SYNC_W-1:0] sync2_ff;
	logic              sck_prev_ff;
	logic              tck_prev_ff;
	logic              wr_prev_ff;
	logic              armed_ff;
	logic              go_smp_ff;
	logic              running_ff;

	wire [SYNC_W-1:0] pins_in = {sample_clk, tap_stage_clk, go_n, wr_n, cs_n, out_en_n,
		reg_select, control_word, sample_in};

	wire                sck_s = sync2_ff[SYNC_W-1];
	wire                tck_s = sync2_ff[SYNC_W-2];
	wire                go_s  = sync2_ff[SYNC_W-3];
	wire                wr_s  = sync2_ff[SYNC_W-4];
	wire                cs_s  = sync2_ff[SYNC_W-5];
	wire                oe_s  = sync2_ff[SYNC_W-6];
	wire [1:0]          sel_s = sync2_ff[SAMPLE_W+CTRL_W +: 2];
	wire [CTRL_W-1:0]   cw_s  = sync2_ff[SAMPLE_W +: CTRL_W];
	wire [SAMPLE_W-1:0] sin_s = sync2_ff[SAMPLE_W-1:0];

	// clocks are sampled, so each stage clock must stay below clk_sys / 2
	wire sck_rise = sck_s & ~sck_prev_ff;
	wire tck_rise = tck_s & ~tck_prev_ff;
	wire go_fall  = sck_rise & go_smp_ff & ~go_s;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sync1_ff <= {PIN_CTL_RST, {(SYNC_W-6){1'b0}}};
			sync2_ff <= {PIN_CTL_RST, {(SYNC_W-6){1'b0}}};
		end else begin
			sync1_ff <= pins_in;
			sync2_ff <= sync1_ff;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sck_prev_ff <= 1'b0;
			tck_prev_ff <= 1'b0;
			go_smp_ff   <= 1'b1;
			running_ff  <= 1'b0;
		end else begin
			sck_prev_ff <= sck_s;
			tck_prev_ff <= tck_s;
			if (sck_rise) go_smp_ff <= go_s;
			if (go_fall) running_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control port
	logic [1:0]        sel_ff;
	logic [CTRL_W-1:0] word_ff;
	logic [CTRL_W-1:0] coarse_cfg_ff;
	logic [CTRL_W-1:0] tap_cfg_ff;
	logic [CTRL_W-1:0] coef_lo_ff;
	logic [COEF_W-1:0] coef_mem [COEF_DEPTH];

	// word and select are held from the last low cycle, so late bus skew is harmless
	wire ld        = wr_s & ~wr_prev_ff & armed_ff;
	wire ld_coarse = ld & (sel_ff == SEL_COARSE);
	wire ld_tap    = ld & (sel_ff == SEL_TAP);
	wire ld_lo     = ld & (sel_ff == SEL_COEF_LO);
	wire ld_hi     = ld & (sel_ff == SEL_COEF_HI);

	wire [CC_RATE_W-1:0] coarse_rate       = coarse_cfg_ff[CC_RATE_LSB +: CC_RATE_W];
	wire                 coarse_bypass     = coarse_cfg_ff[CC_BYP_BIT];
	wire                 tap_stage_bypass  = tap_cfg_ff[TC_BYP_BIT];
	wire                 tap_stage_disable = tap_cfg_ff[TC_DIS_BIT];
	wire [TC_DEC_W-1:0]  tap_dec_m1        = tap_cfg_ff[TC_DEC_LSB +: TC_DEC_W];
	wire [TAP_AW-1:0]    ntap_m1           = tap_cfg_ff[TC_NTAP_LSB +: TAP_AW];
	wire [COEF_AW-1:0]   coef_waddr        = word_ff[CH_ADDR_LSB +: COEF_AW];
	wire [COEF_W-1:0]    coef_wdata        = {word_ff[CH_HI_LSB +: CH_HI_W], coef_lo_ff};

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wr_prev_ff <= 1'b1;
			armed_ff   <= 1'b0;
			sel_ff     <= '0;
			word_ff    <= '0;
		end else begin
			wr_prev_ff <= wr_s;
			armed_ff   <= ~wr_s & ~cs_s;
			if (!wr_s && !cs_s) begin
				sel_ff  <= sel_s;
				word_ff <= cw_s;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			coarse_cfg_ff <= COARSE_CFG_RST;
			tap_cfg_ff    <= TAP_CFG_RST;
			coef_lo_ff    <= '0;
		end else begin
			if (ld_coarse) coarse_cfg_ff <= word_ff;
			if (ld_tap) tap_cfg_ff <= word_ff;
			if (ld_lo) coef_lo_ff <= word_ff;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (ld_hi) coef_mem[coef_waddr] <= coef_wdata;
	end

	////////////////////////////////////////////////////////////////////////
	// coarse section and fifo
	tsd_stream_if #(.W(RESULT_W)) crs_if ();
	tsd_stream_if #(.W(RESULT_W)) fifo_if ();

	tsd_coarse u_coarse (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.in_valid (sck_rise & running_ff),
		.in_data  (sin_s),
		.rate_m1  (coarse_rate),
		.bypass   (coarse_bypass),
		.out      (crs_if.src),
		.overrun  (overrun)
	);

	tsd_fifo #(
		.W     (RESULT_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.wr      (crs_if.snk),
		.rd      (fifo_if.src)
	);

	////////////////////////////////////////////////////////////////////////
	// tap section
	tsd_fir_state_t              fir_st_ff;
	tsd_fir_state_t              nxt_st;
	logic [TAP_AW-1:0]           k_ff;
	logic [TAP_AW-1:0]           nxt_k;
	logic [TAP_AW-1:0]           base_ff;
	logic [TAP_AW-1:0]           wp_ff;
	logic [TC_DEC_W-1:0]         dec_cnt_ff;
	logic signed [ACC_W-1:0]     acc_ff;
	logic signed [ACC_W-1:0]     nxt_acc;
	logic [RESULT_W-1:0]         result_ff;
	logic [RESULT_W-1:0]         nxt_res;
	logic                        valid_ff;
	logic                        nxt_valid;
	logic signed [RESULT_W-1:0]  data_mem [MAX_TAPS];

	// a disabled stage stops draining; the fifo fills and stalls the coarse output
	assign fifo_if.ready = tck_rise & ~tap_stage_disable & (fir_st_ff == TSD_IDLE);

	wire pop       = fifo_if.valid & fifo_if.ready;
	wire fir_store = pop & ~tap_stage_bypass;
	wire fir_start = fir_store & (dec_cnt_ff == tap_dec_m1);
	wire mac_last  = (k_ff == ntap_m1);

	// symmetric taps share one coefficient per mirrored pair
	wire [TAP_AW-1:0]          k_mirror  = ntap_m1 - k_ff;
	wire [TAP_AW-1:0]          coef_idx  = (k_ff <= k_mirror) ? k_ff : k_mirror;
	wire signed [COEF_W-1:0]   coef_rd   = coef_mem[coef_idx[COEF_AW-1:0]];
	wire [TAP_AW-1:0]          rd_addr   = base_ff - k_ff;
	wire signed [RESULT_W-1:0] data_rd   = data_mem[rd_addr];
	wire signed [PROD_W-1:0]   prod      = data_rd * coef_rd;
	wire signed [ACC_W-1:0]    acc_sum   = acc_ff + ACC_W'(prod);
	wire [RESULT_W-1:0]        res_mac   = acc_sum[COEF_FRAC +: RESULT_W];

	always_comb begin
		nxt_st    = fir_st_ff;
		nxt_k     = k_ff;
		nxt_acc   = acc_ff;
		nxt_res   = result_ff;
		nxt_valid = 1'b0;
		case (fir_st_ff)
			TSD_IDLE: begin
				if (pop && tap_stage_bypass) begin
					nxt_res   = fifo_if.data;
					nxt_valid = 1'b1;
				end else if (fir_start) begin
					nxt_st  = TSD_MAC;
					nxt_k   = '0;
					nxt_acc = '0;
				end
			end
			TSD_MAC: begin
				if (tck_rise) begin
					nxt_acc = acc_sum;
					nxt_k   = k_ff + 1'b1;
					if (mac_last) begin
						nxt_st    = TSD_IDLE;
						nxt_res   = res_mac;
						nxt_valid = 1'b1;
					end
				end
			end
			default: nxt_st = TSD_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			fir_st_ff  <= TSD_IDLE;
			k_ff       <= '0;
			base_ff    <= '0;
			wp_ff      <= '0;
			dec_cnt_ff <= '0;
			result_ff  <= '0;
			valid_ff   <= 1'b0;
		end else begin
			fir_st_ff <= nxt_st;
			k_ff      <= nxt_k;
			result_ff <= nxt_res;
			valid_ff  <= nxt_valid;
			if (fir_store) begin
				wp_ff      <= wp_ff + 1'b1;
				base_ff    <= wp_ff;
				dec_cnt_ff <= fir_start ? '0 : dec_cnt_ff + 1'b1;
			end
		end
	end

	// datapath is left uninitialised by reset
	always_ff @(posedge clk_sys) begin
		acc_ff <= nxt_acc;
		if (fir_store) data_mem[wp_ff] <= fifo_if.data;
	end

	assign result_out   = result_ff;
	assign result_oe    = ~oe_s;
	assign result_valid = valid_ff;
	assign running      = running_ff;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_go_fall;
		sck_rise && go_smp_ff && !go_s;
	endsequence

	sequence s_last_step;
		fir_st_ff == TSD_MAC && tck_rise && mac_last;
	endsequence

	property p_cfg_load;
		ld && sel_ff == SEL_TAP |=> tap_cfg_ff == $past(word_ff);
	endproperty
	a_cfg_load: assert property (p_cfg_load) else $error("tap config not loaded");

	property p_reset_cfg;
		disable iff (1'b0) sys_rst |=> tap_stage_disable && !tap_stage_bypass
			&& coarse_rate == '0 && !running_ff;
	endproperty
	a_reset_cfg: assert property (p_reset_cfg) else $error("reset state wrong");

	property p_start;
		s_go_fall |=> running_ff ##1 running_ff;
	endproperty
	a_start: assert property (p_start) else $error("go_n fall did not start");

	property p_byp_pass;
		pop && tap_stage_bypass |=> result_valid && result_out == $past(fifo_if.data);
	endproperty
	a_byp_pass: assert property (p_byp_pass) else $error("bypass word not presented");

	property p_valid_pulse;
		result_valid |=> !result_valid;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("result_valid wider than one cycle");

	property p_valid_tck;
		result_valid |-> $past(tck_rise);
	endproperty
	a_valid_tck: assert property (p_valid_tck) else $error("result_valid off tap clock edge");

	property p_mac_end;
		s_last_step |=> result_valid && fir_st_ff == TSD_IDLE && result_out == $past(res_mac);
	endproperty
	a_mac_end: assert property (p_mac_end) else $error("tap sum not delivered");

	property p_decim;
		fir_store && dec_cnt_ff != tap_dec_m1 |=> fir_st_ff == TSD_IDLE
			&& dec_cnt_ff == $past(dec_cnt_ff) + 1'b1;
	endproperty
	a_decim: assert property (p_decim) else $error("tap section ran off its decimation slot");

	property p_disable;
		tap_stage_disable |-> !fifo_if.ready ##1 !result_valid || $past(fir_st_ff == TSD_MAC);
	endproperty
	a_disable: assert property (p_disable) else $error("disabled tap section drained input");

	property p_oe;
		$fell(oe_s) |-> result_oe [*2];
	endproperty
	a_oe: assert property (p_oe) else $error("result drivers not enabled");

endmodule : tsd_top

`default_nettype wire

// *** verification/tb.sv ***
// tb: self-checking bench for tsd_top
// assumes: tsd_src_model supplies stage clocks and samples
`timescale 1ns/1ps
`default_nettype none

module tb;
	import tsd_pkg::*;

	logic                clk_sys, sys_rst, go_n, wr_n, cs_n, out_en_n;
	logic [1:0]          reg_select;
	logic [CTRL_W-1:0]   control_word;
	logic [SAMPLE_W-1:0] level, sample_in;
	logic                sample_clk, tap_stage_clk;
	logic [RESULT_W-1:0] result_out;
	logic                result_oe, result_valid, running, overrun;
	int                  fails, comparisons, n, ov;
	logic [SAMPLE_W-1:0] vals [3] = '{16'h7fff, 16'h8000, 16'h0001};
	int                  decs [2] = '{1, 15};

	tsd_src_model i_src (
		.clk_sys       (clk_sys),
		.level         (level),
		.sample_clk    (sample_clk),
		.tap_stage_clk (tap_stage_clk),
		.sample_in     (sample_in)
	);

	tsd_top #(.FIFO_D(FIFO_DEPTH)) i_dut (
		.clk_sys       (clk_sys),
		.sys_rst       (sys_rst),
		.sample_clk    (sample_clk),
		.tap_stage_clk (tap_stage_clk),
		.sample_in     (sample_in),
		.go_n          (go_n),
		.wr_n          (wr_n),
		.cs_n          (cs_n),
		.reg_select    (reg_select),
		.control_word  (control_word),
		.out_en_n      (out_en_n),
		.result_out    (result_out),
		.result_oe     (result_oe),
		.result_valid  (result_valid),
		.running       (running),
		.overrun       (overrun)
	);

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("counts: comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results

	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys);
	endtask : cyc

	task automatic chk_word(input logic [RESULT_W-1:0] exp, input logic [RESULT_W-1:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk_word

	task automatic chk_bit(input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk_bit

	// strobe held 4 cycles, data steady well before the rise
	task automatic wr(input logic cs, input logic [1:0] sel, input logic [CTRL_W-1:0] w);
		cyc(1);
		cs_n = cs;
		wr_n = 1'b0;
		reg_select = sel;
		control_word = w;
		cyc(4);
		wr_n = 1'b1;
		cyc(1);
		cs_n = 1'b1;
		cyc(6);
	endtask : wr

	task automatic wait_res(input int k);
		int t;
		int seen;
		t = 0;
		seen = 0;
		while (seen < k && t < 4000) begin
			@(posedge clk_sys);
			#1;
			t++;
			if (result_valid === 1'b1) seen++;
		end
		if (seen < k) begin
			fails++;
			$display("BAD t=%0t exp=%h got=%h", $time, k, seen);
			results();
		end
	endtask : wait_res

	// counts result strobes and overrun pulses over a window
	task automatic count_res(input int win);
		n = 0;
		ov = 0;
		repeat (win) begin
			@(posedge clk_sys);
			#1;
			if (result_valid === 1'b1) n++;
			if (overrun === 1'b1) ov++;
		end
		cyc(1);
	endtask : count_res

	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		go_n = 1'b1;
		wr_n = 1'b1;
		cs_n = 1'b1;
		out_en_n = 1'b1;
		reg_select = 2'h0;
		control_word = 16'h0000;
		level = 16'h1111;
		fails = 0;
		comparisons = 0;
		cyc(8);
		sys_rst = 1'b0;
		cyc(3);
		chk_bit(1'b0, running);
		chk_bit(1'b0, result_valid);
		chk_word(24'h000000, result_out);
		$display("test reset done");

		out_en_n = 1'b0;
		cyc(4);
		chk_bit(1'b1, result_oe);
		out_en_n = 1'b1;
		cyc(4);
		chk_bit(1'b0, result_oe);
		$display("test output enable done");

		// samples before the start must be ignored
		count_res(100);
		chk_bit(1'b0, running);
		chk_word(24'h000000, n[23:0]);
		go_n = 1'b0;
		cyc(30);
		chk_bit(1'b1, running);
		go_n = 1'b1;
		$display("test start done");

		// tap section disabled after reset: fifo fills, coarse drops
		count_res(300);
		chk_word(24'h000000, n[23:0]);
		chk_bit(1'b1, ov != 0);
		$display("test disabled done");

		wr(1'b0, SEL_COARSE, 16'h0400);
		wr(1'b0, SEL_TAP, 16'h0001);
		foreach (vals[i]) begin
			level = vals[i];
			wait_res(12);
			chk_word({vals[i], 8'h00}, result_out);
		end
		count_res(160);
		chk_word(24'd20, n[23:0]);
		$display("test bypass done");

		// write with chip select high must leave the config alone
		wr(1'b1, SEL_TAP, 16'h0002);
		level = 16'h0101;
		wait_res(12);
		chk_word(24'h010100, result_out);
		$display("test deselected write done");

		// one tap, coefficient 0.5 then -1.0
		wr(1'b0, SEL_TAP, 16'h0000);
		wr(1'b0, SEL_COEF_LO, 16'h0000);
		wr(1'b0, SEL_COEF_HI, 16'h0004);
		level = 16'h1234;
		wait_res(12);
		chk_word(24'h091a00, result_out);
		level = 16'hc000;
		wait_res(12);
		chk_word(24'he00000, result_out);
		wr(1'b0, SEL_COEF_HI, 16'h0008);
		level = 16'h1234;
		wait_res(12);
		chk_word(24'hedcc00, result_out);
		$display("test tap filter done");

		// one result per (d+1) words, words every 8 cycles
		foreach (decs[i]) begin
			wr(1'b0, SEL_TAP, CTRL_W'(decs[i] << TC_DEC_LSB));
			cyc(300);
			count_res(640);
			chk_word(24'(640 / (8 * (decs[i] + 1))), n[23:0]);
		end
		$display("test decimation done");

		// three taps, mirrored pair shares coef 0: 0.125, 0.25, 0.125
		level = 16'h1234;
		wr(1'b0, SEL_COEF_LO, 16'h0000);
		wr(1'b0, SEL_COEF_HI, 16'h0001);
		wr(1'b0, SEL_COEF_HI, 16'h0012);
		wr(1'b0, SEL_TAP, 16'h0080);
		wait_res(12);
		chk_word(24'h091a00, result_out);
		$display("test symmetric taps done");

		// coarse factor 4, tap bypassed: one result per four samples
		level = 16'h8000;
		wr(1'b0, SEL_TAP, 16'h0001);
		wr(1'b0, SEL_COARSE, 16'h0003);
		cyc(300);
		count_res(640);
		chk_word(24'd20, n[23:0]);
		chk_word(24'hffffff, result_out);
		$display("test coarse decimation done");
		results();
	end
endmodule : tb

`default_nettype wire

// *** verification/tsd_src_model.sv ***
// tsd_src_model: upstream sample source with divided stage clocks
// assumes: clk_sys free running; level set by the bench
`timescale 1ns/1ps
`default_nettype none

module tsd_src_model
	import tsd_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic [SAMPLE_W-1:0] level,
	output logic                     sample_clk,
	output logic                     tap_stage_clk,
	output logic [SAMPLE_W-1:0]      sample_in
);
	// no reset here: start values by declaration, both variables in one process
	logic [2:0]          phase_ff = 3'h0;
	logic [SAMPLE_W-1:0] word_ff  = 16'h0000;

	assign sample_in = word_ff;

	////////////////////////////////////////////////////////////////////////
	// sample clock divided down from tap clock, so both stay in step
	assign tap_stage_clk = phase_ff[1];
	assign sample_clk    = phase_ff[2];

	// new word only at sample clock fall: stable around the rise
	always @(negedge clk_sys) begin
		phase_ff <= phase_ff + 3'h1;
		if (phase_ff == 3'h7) begin
			word_ff <= level;
		end
	end
endmodule : tsd_src_model

`default_nettype wire
